// >>> include/hs_cfg_defs.svh
// Offsets, field positions, reset values and timing counts for the
// high-side output configuration register bank.
// Assumes a 10 MHz system clock and a 7-bit SPI register address.
`ifndef HS_CFG_DEFS_SVH
`define HS_CFG_DEFS_SVH

// ==========================================================================
// Register addresses (7-bit SPI address space)
`define ADDR_SHUTDOWN_POLICY  7'h10
`define ADDR_SOURCE_A         7'h14
`define ADDR_SOURCE_B         7'h15
`define ADDR_PIN_FUNCTION     7'h17
`define ADDR_PWM_ONE_DUTY     7'h18

// ==========================================================================
// Field positions and masks
`define POS_OV_SD_DISABLE     6
`define POS_UV_SD_DISABLE     5
`define POS_RECOVERY          4
`define MASK_SHUTDOWN_POLICY  8'h70
`define MASK_SOURCE           8'h77
`define RESET_VALUE           8'h00

// ==========================================================================
// Switch source codes
`define SRC_OFF               3'h0
`define SRC_ON                3'h1
`define SRC_TIMER_ONE         3'h2
`define SRC_TIMER_TWO         3'h3
`define SRC_PWM_ONE           3'h4
`define SRC_PWM_TWO           3'h5

// ==========================================================================
// Pin function codes
`define PIN_OFF               3'h4
`define PIN_WAKE              3'h5
`define PIN_LOW_SIDE_ON       3'h6
`define PIN_HIGH_SIDE_ON      3'h7

// ==========================================================================
// PWM timing: 200 Hz or 400 Hz carrier with 255 steps per period
`define CLK_FREQ_HZ           10000000
`define PWM_SLOW_HZ           200
`define PWM_FAST_HZ           400
`define PWM_STEPS             255
`define PWM_SLOW_TICK  (`CLK_FREQ_HZ / (`PWM_SLOW_HZ * `PWM_STEPS))
`define PWM_FAST_TICK  (`CLK_FREQ_HZ / (`PWM_FAST_HZ * `PWM_STEPS))

`endif

// >>> include/hs_cfg_pkg.sv
// Types shared by the high-side output configuration register bank.
// Assumes hs_cfg_defs.svh is on the include path.
package hs_cfg_pkg;

  // ========================================================================
  // Frame receive states
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b00,
    FRAME_SHIFT = 2'b01,
    FRAME_DONE = 2'b10
  } frame_state_t;

  typedef logic [2:0] source_code_t;
  typedef logic [7:0] reg_byte_t;

endpackage

// >>> rtl/hs_cfg_regs.sv
// Configuration register bank for four high-side switches, two high-voltage
// pins and PWM generator one, reached through a 16-bit SPI frame.
// Assumes SPI pins are already synchronous to ref_clk and that fault inputs
// are single-cycle or level indications from the analog switch drivers.
`timescale 1ns/1ps
`include "hs_cfg_defs.svh"

// Behaviour
// - Reserved bits read zero regardless of writes.
// - Bit 6 clear: switch-supply overvoltage shuts all switches off.
// - Bit 5 clear: switch-supply undervoltage shuts all switches off.
// - Bit 4 set: switches resume prior state after supply fault clears.
// - Source codes 000 off, 001 on, 010 timer one, 011 timer two.
// - Source 100 PWM one, 101 PWM two, 110/111 reserved.
// - Switches one/two at bits 2:0/6:4, three/four in next register.
// - Overcurrent or overtemperature clears that switch source field.
// - Pin two function in bits 5:3 with fail output three.
// - Pin one function in bits 2:0 with fail output two.
// - Bits 7:6 give fail output three duty: 20, 10, 5, 2.5 percent.
// - PWM one on fraction equals duty value over 255.
// - Power-on and soft reset clear all registers.
// - Restart keeps shutdown policy bits 6:4, clears the rest.
// - Restart clears both switch source registers.
// - Restart leaves pin function and PWM one duty unchanged.
// - A cyclic timer runs once assigned and on-time written.
// - PWM runs at 200 Hz with select 0, 400 Hz with select 1.
// - Frame: 7-bit address, access-mode bit, data byte.
module hs_cfg_regs (
  // Clock and resets
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    soft_rst,
  input  wire logic                    restart_entry,
  // SPI, synchronous to ref_clk
  input  wire logic                    spi_cs_n,
  input  wire logic                    spi_sck,
  input  wire logic                    spi_mosi,
  output logic                         spi_miso,
  // Supply and switch fault indications
  input  wire logic                    supply_overvoltage,
  input  wire logic                    supply_undervoltage,
  input  wire logic [3:0]              switch_fault,
  // Sources from neighbouring blocks
  input  wire logic                    cyclic_timer_one,
  input  wire logic                    cyclic_timer_two,
  input  wire logic                    pwm_generator_two,
  input  wire logic                    pwm_one_fast,
  // Switch and pin controls
  output logic [3:0]                   switch_on,
  output hs_cfg_pkg::source_code_t     hv_pin_one_function,
  output hs_cfg_pkg::source_code_t     hv_pin_two_function,
  output logic [1:0]                   fail_output_duty,
  output logic                         pwm_generator_one
);
  import hs_cfg_pkg::*;
  default clocking main_cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  localparam int SLOW_TICK = `PWM_SLOW_TICK;
  localparam int FAST_TICK = `PWM_FAST_TICK;

  // ========================================================================
  // Register state
  reg_byte_t    switch_shutdown_policy;
  reg_byte_t    high_side_source_select_a;
  reg_byte_t    high_side_source_select_b;
  reg_byte_t    hv_pin_function_select;
  reg_byte_t    pwm_one_duty;
  reg_byte_t    next_policy;
  reg_byte_t    next_src_a;
  reg_byte_t    next_src_b;
  reg_byte_t    next_pin;
  reg_byte_t    next_duty;
  // Frame receiver state
  frame_state_t frame_state;
  frame_state_t next_frame_state;
  logic [15:0]  shift_in;
  logic [15:0]  next_shift_in;
  logic [4:0]   bit_count;
  logic [4:0]   next_bit_count;
  logic [7:0]   shift_out;
  logic [7:0]   next_shift_out;
  logic         sck_prev;
  logic         write_strobe;
  logic [6:0]   frame_addr;
  logic [7:0]   frame_data;
  reg_byte_t    read_value;
  // Supply fault handling
  logic         supply_cut;
  logic [3:0]   held_off;
  logic [3:0]   next_held_off;
  logic [3:0]   raw_on;
  // PWM generator one
  logic [19:0]  tick_count;
  logic [19:0]  next_tick_count;
  logic [7:0]   phase;
  logic [7:0]   next_phase;

  // ========================================================================
  // SPI frame: address in bits 15:9, write flag bit 8, data byte 7:0.
  // The write flag is taken as set for a write access.
  assign frame_addr   = shift_in[15:9];
  assign frame_data   = shift_in[7:0];
  assign write_strobe = (frame_state == FRAME_DONE) && shift_in[8];

  // Readback select. After eight bits the address sits in bits 7:1.
  always_comb begin
    unique case (shift_in[7:1])
      `ADDR_SHUTDOWN_POLICY: read_value = switch_shutdown_policy;
      `ADDR_SOURCE_A:        read_value = high_side_source_select_a;
      `ADDR_SOURCE_B:        read_value = high_side_source_select_b;
      `ADDR_PIN_FUNCTION:    read_value = hv_pin_function_select;
      `ADDR_PWM_ONE_DUTY:    read_value = pwm_one_duty;
      default:               read_value = `RESET_VALUE;
    endcase
  end

  // Receiver sequencing: shift on rising sck, latch read byte after the
  // address byte so the data phase can return it on the same frame.
  always_comb begin
    next_frame_state = frame_state;
    next_shift_in    = shift_in;
    next_bit_count   = bit_count;
    next_shift_out   = shift_out;
    unique case (frame_state)
      FRAME_IDLE: begin
        next_bit_count = 5'd0;
        if (!spi_cs_n) begin
          next_frame_state = FRAME_SHIFT;
        end
      end
      FRAME_SHIFT: begin
        if (spi_cs_n) begin
          next_frame_state = (bit_count == 5'd16) ? FRAME_DONE : FRAME_IDLE;
        end else if (spi_sck && !sck_prev) begin
          next_shift_in  = {shift_in[14:0], spi_mosi};
          next_bit_count = bit_count + 5'd1;
          if (bit_count == 5'd8) begin
            next_shift_out = read_value;
          end else begin
            next_shift_out = {shift_out[6:0], 1'b0};
          end
        end
      end
      FRAME_DONE: next_frame_state = FRAME_IDLE;
      default:    next_frame_state = FRAME_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frame_state <= FRAME_IDLE;
      shift_in    <= 16'h0000;
      bit_count   <= 5'd0;
      shift_out   <= 8'h00;
      sck_prev    <= 1'b0;
    end else begin
      frame_state <= next_frame_state;
      shift_in    <= next_shift_in;
      bit_count   <= next_bit_count;
      shift_out   <= next_shift_out;
      sck_prev    <= spi_sck;
    end
  end

  assign spi_miso = shift_out[7];

  // ========================================================================
  // Register updates. Fault clearing is applied after the write so a
  // fault in the same cycle as a write still leaves the field off.
  always_comb begin
    next_policy = switch_shutdown_policy;
    next_src_a  = high_side_source_select_a;
    next_src_b  = high_side_source_select_b;
    next_pin    = hv_pin_function_select;
    next_duty   = pwm_one_duty;
    if (write_strobe) begin
      unique case (frame_addr)
        `ADDR_SHUTDOWN_POLICY:
          next_policy = frame_data & `MASK_SHUTDOWN_POLICY;
        `ADDR_SOURCE_A: next_src_a = frame_data & `MASK_SOURCE;
        `ADDR_SOURCE_B: next_src_b = frame_data & `MASK_SOURCE;
        `ADDR_PIN_FUNCTION: next_pin = frame_data;
        `ADDR_PWM_ONE_DUTY: next_duty = frame_data;
        default: next_policy = switch_shutdown_policy;
      endcase
    end
    // Overcurrent or overtemperature turns the source field to off.
    if (switch_fault[0]) next_src_a[2:0] = `SRC_OFF;
    if (switch_fault[1]) next_src_a[6:4] = `SRC_OFF;
    if (switch_fault[2]) next_src_b[2:0] = `SRC_OFF;
    if (switch_fault[3]) next_src_b[6:4] = `SRC_OFF;
    // Restart keeps policy and pin/duty configuration, drops sources.
    if (restart_entry) begin
      next_policy = switch_shutdown_policy & `MASK_SHUTDOWN_POLICY;
      next_src_a  = `RESET_VALUE;
      next_src_b  = `RESET_VALUE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      switch_shutdown_policy    <= `RESET_VALUE;
      high_side_source_select_a <= `RESET_VALUE;
      high_side_source_select_b <= `RESET_VALUE;
      hv_pin_function_select    <= `RESET_VALUE;
      pwm_one_duty              <= `RESET_VALUE;
    end else begin
      switch_shutdown_policy    <= next_policy;
      high_side_source_select_a <= next_src_a;
      high_side_source_select_b <= next_src_b;
      hv_pin_function_select    <= next_pin;
      pwm_one_duty              <= next_duty;
    end
  end

  // ========================================================================
  // Source decode per switch; reserved codes fall to off. Timer inputs
  // only toggle once the timer block has an on-time written.
  function automatic logic pick(input source_code_t code,
                                input logic t1, t2, p1, p2);
    unique case (code)
      `SRC_ON:        pick = 1'b1;
      `SRC_TIMER_ONE: pick = t1;
      `SRC_TIMER_TWO: pick = t2;
      `SRC_PWM_ONE:   pick = p1;
      `SRC_PWM_TWO:   pick = p2;
      default:        pick = 1'b0;
    endcase
  endfunction

  always_comb begin
    raw_on[0] = pick(high_side_source_select_a[2:0], cyclic_timer_one,
                     cyclic_timer_two, pwm_generator_one, pwm_generator_two);
    raw_on[1] = pick(high_side_source_select_a[6:4], cyclic_timer_one,
                     cyclic_timer_two, pwm_generator_one, pwm_generator_two);
    raw_on[2] = pick(high_side_source_select_b[2:0], cyclic_timer_one,
                     cyclic_timer_two, pwm_generator_one, pwm_generator_two);
    raw_on[3] = pick(high_side_source_select_b[6:4], cyclic_timer_one,
                     cyclic_timer_two, pwm_generator_one, pwm_generator_two);
  end

  // ========================================================================
  // Supply fault shutdown. Without recovery a cut switch stays off until
  // any register write frame or restart (either one releases all four switches).
  assign supply_cut =
    (supply_overvoltage && !switch_shutdown_policy[`POS_OV_SD_DISABLE]) ||
    (supply_undervoltage && !switch_shutdown_policy[`POS_UV_SD_DISABLE]);
  // Armed for the whole cut, so no switch blips on as the cut ends.
  always_comb begin
    next_held_off = held_off;
    if (write_strobe || restart_entry) begin
      next_held_off = 4'h0;
    end
    if (supply_cut && !switch_shutdown_policy[`POS_RECOVERY]) begin
      next_held_off = 4'hF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      held_off <= 4'h0;
    end else begin
      held_off <= next_held_off;
    end
  end

  assign switch_on = (supply_cut ? 4'h0 : raw_on & ~held_off);
  assign hv_pin_one_function = hv_pin_function_select[2:0];
  assign hv_pin_two_function = hv_pin_function_select[5:3];
  assign fail_output_duty    = hv_pin_function_select[7:6];

  // ========================================================================
  // PWM generator one: 255 phase steps, step length chosen by frequency.
  always_comb begin
    next_tick_count = tick_count + 20'd1;
    next_phase      = phase;
    if (tick_count >= 20'(pwm_one_fast ? FAST_TICK - 1 : SLOW_TICK - 1)) begin
      next_tick_count = 20'd0;
      next_phase = (phase == 8'd254) ? 8'd0 : phase + 8'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_count        <= 20'd0;
      phase             <= 8'd0;
      pwm_generator_one <= 1'b0;
    end else begin
      tick_count        <= next_tick_count;
      phase             <= next_phase;
      pwm_generator_one <= (phase < pwm_one_duty);
    end
  end

  // ========================================================================
  // Checks
  sequence s_write_a;
    write_strobe && frame_addr == `ADDR_SOURCE_A && !restart_entry;
  endsequence
  AST_RESERVED_ZERO: assert property (
    (switch_shutdown_policy[3:0] == 4'h0) &&
    !switch_shutdown_policy[7] && !high_side_source_select_a[7])
    else $error("Reserved bit set.");
  AST_OV_CUT: assert property (
    supply_overvoltage && !switch_shutdown_policy[6] |-> switch_on == 4'h0)
    else $error("Overvoltage did not cut switches.");
  AST_UV_CUT: assert property (
    supply_undervoltage && !switch_shutdown_policy[5] |-> switch_on == 4'h0)
    else $error("Undervoltage did not cut switches.");
  AST_FORCED_ON: assert property (
    high_side_source_select_a[2:0] == 3'h1 && !supply_cut && !held_off[0]
    |-> switch_on[0])
    else $error("On code did not drive switch.");
  AST_RESERVED_OFF: assert property (
    high_side_source_select_b[6:5] == 2'b11 |-> !switch_on[3])
    else $error("Reserved code drove switch.");
  AST_FAULT_CLEAR: assert property (
    switch_fault[2] |=> high_side_source_select_b[2:0] == 3'h0)
    else $error("Fault did not clear source.");
  AST_WRITE_A: assert property (
    s_write_a ##0 (switch_fault == 4'h0) && !soft_rst
    |=> high_side_source_select_a == ($past(frame_data) & 8'h77))
    else $error("Source write lost.");
  AST_RESTART: assert property (
    restart_entry && !soft_rst |=> high_side_source_select_b == 8'h00 &&
    pwm_one_duty == $past(pwm_one_duty) &&
    switch_shutdown_policy == ($past(switch_shutdown_policy) & 8'h70))
    else $error("Restart values wrong.");
  AST_SOFT_RESET: assert property (
    soft_rst |=> hv_pin_function_select == 8'h00 && pwm_one_duty == 8'h00)
    else $error("Soft reset did not clear.");
  AST_PWM_OFF: assert property (
    pwm_one_duty == 8'h00 [*2] |-> !pwm_generator_one)
    else $error("PWM on at zero duty.");

endmodule // hs_cfg_regs

// >>> verif/spi_mcu_model.sv
// Microcontroller model that issues 16-bit register frames on the SPI pins.
// Assumes the block samples sck with ref_clk and shifts miso on sck rises.
`timescale 1ns/1ps

module spi_mcu_model (
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);

  // ==========================================================================
  // Idle levels
  // Select high and clock parked low, since sck never runs outside a frame.
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_mosi = 1'b0;
  end

  // ==========================================================================
  // Frame transfer
  // The model never picks a cyclic sense filter, so no timer is owed.
  // The sck high phase lasts two cycles and the low phase four, so the sampler sees every level.
  task automatic xfer(input logic [6:0] addr, input logic wr,
                      input logic [7:0] wdata, input int nbits,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word  = {addr, wr, wdata};
    rdata = 8'h00;
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge ref_clk);
      spi_mosi <= word[15 - i];
      @(posedge ref_clk);
      spi_sck <= 1'b1;
      repeat (2) @(posedge ref_clk);
      spi_sck <= 1'b0;
      repeat (2) @(posedge ref_clk);
      if (i >= 8) begin
        rdata = {rdata[6:0], spi_miso};
      end
    end
    @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    // A released data line must not keep showing its last bit.
    spi_mosi <= ~spi_mosi;
  endtask

endmodule // spi_mcu_model

// >>> verif/tb_high_side_output_config_regs.sv
// Self-checking bench for the high-side output configuration registers.
// Assumes the SPI model in spi_mcu_model.sv and the defines header.
`timescale 1ns/1ps
`include "hs_cfg_defs.svh"

module tb_high_side_output_config_regs;
  import hs_cfg_pkg::*;

  // ==========================================================================
  // Signals
  logic         ref_clk, sys_rst, soft_rst, restart_entry;
  logic         spi_cs_n, spi_sck, spi_mosi, spi_miso;
  logic         supply_overvoltage, supply_undervoltage;
  logic [3:0]   switch_fault, switch_on;
  logic         cyclic_timer_one, cyclic_timer_two, pwm_generator_two;
  logic         pwm_one_fast, pwm_generator_one;
  source_code_t hv_pin_one_function, hv_pin_two_function;
  logic [1:0]   fail_output_duty;
  int           err_total;
  int           checked;

  spi_mcu_model u_spi_mcu_model (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  hs_cfg_regs u_hs_cfg_regs (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .restart_entry(restart_entry),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .supply_overvoltage(supply_overvoltage),
    .supply_undervoltage(supply_undervoltage), .switch_fault(switch_fault),
    .cyclic_timer_one(cyclic_timer_one), .cyclic_timer_two(cyclic_timer_two),
    .pwm_generator_two(pwm_generator_two), .pwm_one_fast(pwm_one_fast),
    .switch_on(switch_on), .hv_pin_one_function(hv_pin_one_function),
    .hv_pin_two_function(hv_pin_two_function),
    .fail_output_duty(fail_output_duty),
    .pwm_generator_one(pwm_generator_one));

  // ==========================================================================
  // Clock, verdict and helpers
  // The clock runs at 10 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Lets the edge's updates land before outputs are looked at.
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  // A write lands two cycles after select rises; three covers it.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_spi_mcu_model.xfer(a, 1'b1, d, 16, unused);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic rd_check(input string what, input logic [6:0] a,
                          input logic [7:0] exp);
    logic [7:0] got;
    u_spi_mcu_model.xfer(a, 1'b0, 8'h00, 16, got);
    repeat (3) @(posedge ref_clk);
    check_byte(what, exp, got);
  endtask

  task automatic set_supply(input logic ov, input logic uv);
    @(posedge ref_clk);
    supply_overvoltage  <= ov;
    supply_undervoltage <= uv;
    settle();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    rd_check("policy", `ADDR_SHUTDOWN_POLICY, 8'h00);
    rd_check("source_a", `ADDR_SOURCE_A, 8'h00);
    rd_check("source_b", `ADDR_SOURCE_B, 8'h00);
    rd_check("pin_fn", `ADDR_PIN_FUNCTION, 8'h00);
    rd_check("pwm_duty", `ADDR_PWM_ONE_DUTY, 8'h00);
    check_byte("switch_on", 8'h00, {4'h0, switch_on});
  endtask

  // A short frame and a read frame carrying data must change nothing.
  task automatic test_bad_frame();
    logic [7:0] unused;
    u_spi_mcu_model.xfer(`ADDR_SHUTDOWN_POLICY, 1'b1, 8'h70, 15, unused);
    repeat (3) @(posedge ref_clk);
    rd_check("short", `ADDR_SHUTDOWN_POLICY, 8'h00);
    u_spi_mcu_model.xfer(`ADDR_SHUTDOWN_POLICY, 1'b0, 8'h70, 16, unused);
    repeat (3) @(posedge ref_clk);
    rd_check("rdmode", `ADDR_SHUTDOWN_POLICY, 8'h00);
  endtask

  task automatic test_reserved();
    logic [7:0] v[4];
    v = '{8'hFF, 8'h65, 8'h9A, 8'h30};
    wr(`ADDR_SHUTDOWN_POLICY, 8'hFF);
    rd_check("policy", `ADDR_SHUTDOWN_POLICY, 8'h70);
    wr(`ADDR_SOURCE_A, 8'hFF);
    rd_check("source_a", `ADDR_SOURCE_A, 8'h77);
    check_byte("switch_on", 8'h00, {4'h0, switch_on});
    wr(7'h11, 8'hAA);
    rd_check("unmapped", 7'h11, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_PIN_FUNCTION, v[i]);
      settle();
      check_byte("pin_one", 8'(v[i][2:0]), 8'(hv_pin_one_function));
      check_byte("pin_two", 8'(v[i][5:3]), 8'(hv_pin_two_function));
      check_byte("fo_duty", 8'(v[i][7:6]), 8'(fail_output_duty));
    end
    wr(`ADDR_SHUTDOWN_POLICY, 8'h00);
  endtask

  // Expected enable for a source code; pass 0 raises timer one, PWM two
  // and full PWM one duty, pass 1 raises timer two with zero duty.
  function automatic logic on_for(input int code, input int pass);
    case (code)
      1: return 1'b1;
      2, 4, 5: return pass == 0;
      3: return pass == 1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic test_sources();
    logic [2:0] code[4];
    logic [3:0] exp_on;
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge ref_clk);
      cyclic_timer_one  <= (pass == 0);
      cyclic_timer_two  <= (pass == 1);
      pwm_generator_two <= (pass == 0);
      wr(`ADDR_PWM_ONE_DUTY, (pass == 0) ? 8'hFF : 8'h00);
      for (int c = 0; c < 8; c++) begin
        for (int k = 0; k < 4; k++) begin
          code[k]   = 3'((c + k) % 8);
          exp_on[k] = on_for((c + k) % 8, pass);
        end
        wr(`ADDR_SOURCE_A, {1'b0, code[1], 1'b0, code[0]});
        wr(`ADDR_SOURCE_B, {1'b0, code[3], 1'b0, code[2]});
        settle();
        check_byte("switch_on", 8'(exp_on),
                   8'(switch_on));
      end
    end
  endtask

  task automatic test_supply();
    wr(`ADDR_SOURCE_B, 8'h00);
    wr(`ADDR_SOURCE_A, 8'h11);
    set_supply(1'b1, 1'b0);
    check_byte("ov_off", 8'h00, {4'h0, switch_on});
    set_supply(1'b0, 1'b0);
    check_byte("no_recover", 8'h00, {4'h0, switch_on});
    wr(`ADDR_SHUTDOWN_POLICY, 8'h10);
    set_supply(1'b0, 1'b1);
    check_byte("uv_off", 8'h00, {4'h0, switch_on});
    set_supply(1'b0, 1'b0);
    check_byte("recover", 8'h03, {4'h0, switch_on});
    wr(`ADDR_SHUTDOWN_POLICY, 8'h60);
    set_supply(1'b1, 1'b1);
    check_byte("sd_disabled", 8'h03, {4'h0, switch_on});
    set_supply(1'b0, 1'b0);
  endtask

  task automatic test_switch_fault();
    wr(`ADDR_SOURCE_B, 8'h11);
    @(posedge ref_clk);
    switch_fault <= 4'h4;
    @(posedge ref_clk);
    switch_fault <= 4'h0;
    settle();
    check_byte("switch_on", 8'h0B, {4'h0, switch_on});
    rd_check("source_b", `ADDR_SOURCE_B, 8'h10);
    rd_check("source_a", `ADDR_SOURCE_A, 8'h11);
  endtask

  // One full fast period is counted, so the phase does not matter.
  task automatic test_pwm();
    int span;
    int high;
    int exp_high;
    span     = `PWM_FAST_TICK * `PWM_STEPS;
    exp_high = 128 * span / 255;
    high     = 0;
    wr(`ADDR_SOURCE_A, 8'h04);
    wr(`ADDR_PWM_ONE_DUTY, 8'h80);
    @(posedge ref_clk);
    pwm_one_fast <= 1'b1;
    repeat (span) begin
      settle();
      high += int'(pwm_generator_one === 1'b1);
    end
    check_byte("pwm_frac", 8'h01, 8'((high > exp_high - 150) &&
               (high < exp_high + 150)));
  endtask

  task automatic test_restart();
    wr(`ADDR_SHUTDOWN_POLICY, 8'hFF);
    wr(`ADDR_PIN_FUNCTION, 8'hA5);
    wr(`ADDR_PWM_ONE_DUTY, 8'h3C);
    wr(`ADDR_SOURCE_A, 8'h11);
    @(posedge ref_clk);
    restart_entry <= 1'b1;
    @(posedge ref_clk);
    restart_entry <= 1'b0;
    settle();
    check_byte("switch_on", 8'h00, {4'h0, switch_on});
    rd_check("policy", `ADDR_SHUTDOWN_POLICY, 8'h70);
    rd_check("source_a", `ADDR_SOURCE_A, 8'h00);
    rd_check("pin_fn", `ADDR_PIN_FUNCTION, 8'hA5);
    rd_check("pwm_duty", `ADDR_PWM_ONE_DUTY, 8'h3C);
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    test_reset();
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {soft_rst, restart_entry, supply_overvoltage, supply_undervoltage} = 4'h0;
    {cyclic_timer_one, cyclic_timer_two, pwm_generator_two} = 3'h0;
    switch_fault = 4'h0;
    pwm_one_fast = 1'b0;
    sys_rst      = 1'b1;
    err_total    = 0;
    checked      = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    test_reset();
    test_bad_frame();
    test_reserved();
    test_sources();
    test_supply();
    test_switch_fault();
    test_pwm();
    test_restart();
    complete_run();
  end

  // The scenarios need about 33000 cycles; this leaves ample margin.
  initial begin
    repeat (95000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end

endmodule // tb_high_side_output_config_regs
